/* shared/line_iface_params.svh */
`ifndef LINE_IFACE_PARAMS_SVH
`define LINE_IFACE_PARAMS_SVH

`define ADDR_W            6
`define CHAN_SEL_BIT      5
`define OFS_REVISION      5'h00
`define OFS_SW_RESET      5'h01
`define OFS_TERM          5'h02
`define OFS_JITTER_ATTEN_CONFIG          5'h03
`define OFS_TCF_MAIN      5'h04
`define OFS_TCF_PULSE     5'h05
`define OFS_TCF_SCALE     5'h06
`define OFS_TCF_WAVE_ACC  5'h07
`define OFS_TCF_WAVE_DAT  5'h08
`define OFS_RCF_MAIN      5'h09
`define OFS_RCF_EQ_LOS    5'h0a
`define OFS_RCF_SLICE     5'h0b
`define OFS_DIAG_PATT     5'h0c
`define OFS_LOOPBACK      5'h0d
`define OFS_RSVD_LO       5'h0e
`define OFS_RSVD_HI       5'h11
`define OFS_ERR_CTRL      5'h12
`define OFS_IRQ_MASK_LINE 5'h13
`define OFS_IRQ_MASK_ERR  5'h14
`define OFS_IRQ_EDGE      5'h15
`define OFS_LINE_STATUS   5'h16
`define OFS_LOOP_STATUS   5'h17
`define OFS_IRQ_STAT_LINE 5'h18
`define OFS_IRQ_STAT_ERR  5'h19
`define OFS_CNT_LOW       5'h1a
`define OFS_CNT_HIGH      5'h1b
`define OFS_GLOBAL_CFG    5'h00
`define OFS_INT_CHANNEL   5'h01

`define MASK_TERM         8'h3f
`define MASK_JITTER_ATTEN_CONFIG         8'h3f
`define MASK_TCF_MAIN     8'h1f
`define MASK_TCF_PULSE    8'h3f
`define MASK_TCF_SCALE    8'h3f
`define MASK_TCF_WAVE_ACC 8'hff
`define MASK_TCF_WAVE_DAT 8'h7f
`define MASK_RCF_MAIN     8'h1f
`define MASK_RCF_EQ_LOS   8'h5f
`define MASK_RCF_SLICE    8'h33
`define MASK_DIAG_PATT    8'h7f
`define MASK_LOOPBACK     8'h07
`define MASK_ERR_CTRL     8'h7f
`define MASK_IRQ_LINE     8'h1f
`define MASK_IRQ_ERR      8'hff
`define MASK_LOOP_STATUS  8'h20
`define MASK_GLOBAL_CFG   8'hcf
`define MASK_INT_CHANNEL  8'h03

`define DEF_JITTER_ATTEN_CONFIG          8'h20
`define DEF_TCF_PULSE     8'h10
`define DEF_GLOBAL_CFG    8'h04
`define DEF_ZERO          8'h00

`define TCF_MAIN_T_OFF    4
`define TCF_PULSE_THZ     4
`define GCF_COPY          3
`define GCF_IRQ_GLB_MASK  2

`define CLK_PERIOD_NS     40
`define SW_RESET_NS       1000
`define SW_RESET_CYCLES   (`SW_RESET_NS / `CLK_PERIOD_NS)

`endif

/* shared/line_iface_pkg.sv */
package line_iface_pkg;

    typedef logic [7:0] byte_type;

    typedef struct packed {
        byte_type term;
        byte_type jitter_atten_config;
        byte_type tcf_main;
        byte_type tcf_pulse;
        byte_type tcf_scale;
        byte_type tcf_wave_acc;
        byte_type tcf_wave_dat;
        byte_type rcf_main;
        byte_type rcf_eq_los;
        byte_type rcf_slice;
        byte_type diag_patt;
        byte_type loopback;
        byte_type err_ctrl;
        byte_type irq_mask_line;
        byte_type irq_mask_err;
        byte_type irq_edge;
    } chan_cfg_type;

    typedef struct packed {
        logic [7:0] cnt;
    } sw_reset_state_type;

    typedef struct packed {
        byte_type   global_cfg;
        byte_type   rdata;
        logic [1:0] line_irq_rd;
        logic [1:0] err_irq_rd;
    } top_state_type;

endpackage

/* core/sw_reset_timer.sv */
`timescale 1ns/100ps
`include "line_iface_params.svh"

module sw_reset_timer #(
    parameter logic [7:0] CYCLES = 8'(`SW_RESET_CYCLES)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic trigger,
    output logic      busy
);

    line_iface_pkg::sw_reset_state_type q, d;

    always_comb begin
        d = q;
        if (!rst_n) begin
            d.cnt = 8'h00;
        end else if (trigger && q.cnt == 8'h00) begin
            d.cnt = CYCLES;
        end else if (q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign busy = (q.cnt != 8'h00);

endmodule

/* core/chan_regs.sv */
`timescale 1ns/100ps
`include "line_iface_params.svh"

module chan_regs (
    input  wire logic                 clk,
    input  wire logic                 srst_n,
    input  wire logic                 wr_en,
    input  wire logic [4:0]           wr_ofs,
    input  wire logic [7:0]           wr_data,
    output line_iface_pkg::chan_cfg_type cfg
);

    line_iface_pkg::chan_cfg_type q, d;

    always_comb begin
        d = q;
        if (!srst_n) begin
            d = '0;
            d.jitter_atten_config      = `DEF_JITTER_ATTEN_CONFIG;
            d.tcf_pulse = `DEF_TCF_PULSE;
        end else if (wr_en) begin
            // Unused bit positions are never stored
            unique case (wr_ofs)
                `OFS_TERM:          d.term = wr_data & `MASK_TERM;
                `OFS_JITTER_ATTEN_CONFIG:          d.jitter_atten_config = wr_data & `MASK_JITTER_ATTEN_CONFIG;
                `OFS_TCF_MAIN:      d.tcf_main = wr_data & `MASK_TCF_MAIN;
                `OFS_TCF_PULSE:     d.tcf_pulse = wr_data & `MASK_TCF_PULSE;
                `OFS_TCF_SCALE:     d.tcf_scale = wr_data & `MASK_TCF_SCALE;
                `OFS_TCF_WAVE_ACC:  d.tcf_wave_acc = wr_data;
                `OFS_TCF_WAVE_DAT:
                    d.tcf_wave_dat = wr_data & `MASK_TCF_WAVE_DAT;
                `OFS_RCF_MAIN:      d.rcf_main = wr_data & `MASK_RCF_MAIN;
                `OFS_RCF_EQ_LOS:    d.rcf_eq_los = wr_data & `MASK_RCF_EQ_LOS;
                `OFS_RCF_SLICE:     d.rcf_slice = wr_data & `MASK_RCF_SLICE;
                `OFS_DIAG_PATT:     d.diag_patt = wr_data & `MASK_DIAG_PATT;
                `OFS_LOOPBACK:      d.loopback = wr_data & `MASK_LOOPBACK;
                `OFS_ERR_CTRL:      d.err_ctrl = wr_data & `MASK_ERR_CTRL;
                `OFS_IRQ_MASK_LINE: d.irq_mask_line = wr_data & `MASK_IRQ_LINE;
                `OFS_IRQ_MASK_ERR:  d.irq_mask_err = wr_data;
                `OFS_IRQ_EDGE:      d.irq_edge = wr_data & `MASK_IRQ_LINE;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign cfg = q;

endmodule

/* core/line_iface_regs.sv */
`timescale 1ns/100ps
`include "line_iface_params.svh"

module line_iface_regs #(
    // Arbitrary value
    parameter logic [7:0] REVISION = 8'h5a
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [`ADDR_W-1:0]         host_addr,
    input  wire logic                       host_wr,
    input  wire logic                       host_rd,
    input  wire logic [7:0]                 host_wdata,
    output logic [7:0]                      host_rdata,
    input  wire logic [1:0][7:0]            line_status_in,
    input  wire logic [1:0][7:0]            loop_status_in,
    input  wire logic [1:0][7:0]            irq_stat_line_in,
    input  wire logic [1:0][7:0]            irq_stat_err_in,
    input  wire logic [1:0][15:0]           err_count_in,
    input  wire logic [1:0]                 int_channel_in,
    output line_iface_pkg::chan_cfg_type [1:0] ch_cfg,
    output logic [1:0]                      line_drv_en,
    output logic [1:0]                      line_irq_rd,
    output logic [1:0]                      err_irq_rd,
    output logic [1:0]                      monitor_sel,
    output logic                            irq_global_mask,
    output logic [1:0]                      irq_pin_mode,
    output logic                            sw_reset_active
);

    line_iface_pkg::top_state_type q, d;

    logic       srst_n;
    logic       sw_busy;
    logic       chan;
    logic [4:0] ofs;
    logic       is_local;
    logic       is_reserved;
    logic       wr_ok;
    logic       rd_ok;
    logic       reset_wr;
    logic       local_wr;
    logic       copy_mode;
    logic [1:0] chan_wr;

    assign chan = host_addr[`CHAN_SEL_BIT];
    assign ofs  = host_addr[4:0];

    assign is_local    = (ofs >= `OFS_TERM) && (ofs <= `OFS_CNT_HIGH);
    assign is_reserved = (ofs >= `OFS_RSVD_LO) && (ofs <= `OFS_RSVD_HI);

    // Accesses during a software reset are dropped
    assign wr_ok = host_wr && !sw_busy;
    assign rd_ok = host_rd && !sw_busy && !host_wr;

    assign reset_wr = wr_ok && !chan && (ofs == `OFS_SW_RESET);

    assign local_wr  = wr_ok && is_local && !is_reserved;
    assign copy_mode = q.global_cfg[`GCF_COPY];

    // Local write steers the addressed channel, or both channels when the copy bit is set
    always_comb begin
        chan_wr[0] = local_wr && (!chan || copy_mode);
        chan_wr[1] = local_wr && (chan || copy_mode);
    end

    sw_reset_timer u_sw_reset (
        .clk     (clk),
        .rst_n   (rst_n),
        .trigger (reset_wr),
        .busy    (sw_busy)
    );

    assign srst_n = rst_n && !sw_busy;

    chan_regs u_chan1 (
        .clk     (clk),
        .srst_n  (srst_n),
        .wr_en   (chan_wr[0]),
        .wr_ofs  (ofs),
        .wr_data (host_wdata),
        .cfg     (ch_cfg[0])
    );

    chan_regs u_chan2 (
        .clk     (clk),
        .srst_n  (srst_n),
        .wr_en   (chan_wr[1]),
        .wr_ofs  (ofs),
        .wr_data (host_wdata),
        .cfg     (ch_cfg[1])
    );

    function automatic logic [7:0] local_read(
        input line_iface_pkg::chan_cfg_type c,
        input logic [4:0]                   o,
        input logic [7:0]                   line_st,
        input logic [7:0]                   loop_st,
        input logic [7:0]                   irq_line,
        input logic [7:0]                   irq_err,
        input logic [15:0]                  cnt
    );
        logic [7:0] r;
        r = 8'h00;
        unique case (o)
            `OFS_TERM:          r = c.term;
            `OFS_JITTER_ATTEN_CONFIG:          r = c.jitter_atten_config;
            `OFS_TCF_MAIN:      r = c.tcf_main;
            `OFS_TCF_PULSE:     r = c.tcf_pulse;
            `OFS_TCF_SCALE:     r = c.tcf_scale;
            `OFS_TCF_WAVE_ACC:  r = c.tcf_wave_acc;
            `OFS_TCF_WAVE_DAT:  r = c.tcf_wave_dat;
            `OFS_RCF_MAIN:      r = c.rcf_main;
            `OFS_RCF_EQ_LOS:    r = c.rcf_eq_los;
            `OFS_RCF_SLICE:     r = c.rcf_slice;
            `OFS_DIAG_PATT:     r = c.diag_patt;
            `OFS_LOOPBACK:      r = c.loopback;
            `OFS_ERR_CTRL:      r = c.err_ctrl;
            `OFS_IRQ_MASK_LINE: r = c.irq_mask_line;
            `OFS_IRQ_MASK_ERR:  r = c.irq_mask_err;
            `OFS_IRQ_EDGE:      r = c.irq_edge;
            `OFS_LINE_STATUS:   r = line_st & `MASK_IRQ_LINE;
            `OFS_LOOP_STATUS:   r = loop_st & `MASK_LOOP_STATUS;
            `OFS_IRQ_STAT_LINE: r = irq_line & `MASK_IRQ_LINE;
            `OFS_IRQ_STAT_ERR:  r = irq_err;
            `OFS_CNT_LOW:       r = cnt[7:0];
            `OFS_CNT_HIGH:      r = cnt[15:8];
            default:            r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] global_read(
        input logic       c,
        input logic [4:0] o,
        input logic [7:0] global_configuration,
        input logic [1:0] int_ch
    );
        logic [7:0] r;
        r = 8'h00;
        if (!c && o == `OFS_REVISION) begin
            r = REVISION;
        end else if (c && o == `OFS_GLOBAL_CFG) begin
            r = global_configuration & `MASK_GLOBAL_CFG;
        end else if (c && o == `OFS_INT_CHANNEL) begin
            r = {6'h00, int_ch};
        end
        return r;
    endfunction

    always_comb begin
        d = q;
        d.line_irq_rd = 2'b00;
        d.err_irq_rd  = 2'b00;
        if (!srst_n) begin
            d.global_cfg = `DEF_GLOBAL_CFG;
            d.rdata      = 8'h00;
        end else begin
            // Revision and reset bytes never stored
            // Global config shared by both channels
            if (wr_ok && chan && ofs == `OFS_GLOBAL_CFG) begin
                d.global_cfg = host_wdata & `MASK_GLOBAL_CFG;
            end
            if (rd_ok) begin
                if (is_local) begin
                    d.rdata = local_read(ch_cfg[chan], ofs,
                                         line_status_in[chan],
                                         loop_status_in[chan],
                                         irq_stat_line_in[chan],
                                         irq_stat_err_in[chan],
                                         err_count_in[chan]);
                end else begin
                    d.rdata = global_read(chan, ofs, q.global_cfg,
                                          int_channel_in);
                end
                // Status-read pulses let the event logic acknowledge
                if (ofs == `OFS_IRQ_STAT_LINE) begin
                    d.line_irq_rd[chan] = 1'b1;
                end
                if (ofs == `OFS_IRQ_STAT_ERR) begin
                    d.err_irq_rd[chan] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign host_rdata      = q.rdata;
    assign line_irq_rd     = q.line_irq_rd;
    assign err_irq_rd      = q.err_irq_rd;
    assign monitor_sel     = q.global_cfg[7:6];
    assign irq_global_mask = q.global_cfg[`GCF_IRQ_GLB_MASK];
    assign irq_pin_mode    = q.global_cfg[1:0];
    assign sw_reset_active = sw_busy;

    // Driver off until software clears the high-z bit
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            line_drv_en[i] = srst_n
                && !ch_cfg[i].tcf_pulse[`TCF_PULSE_THZ]
                && !ch_cfg[i].tcf_main[`TCF_MAIN_T_OFF];
        end
    end

endmodule

/* dv/line_iface_regs_assertions.sv */
`timescale 1ns/100ps
`include "line_iface_params.svh"

module line_iface_regs_checker #(
    parameter logic [7:0] REVISION = 8'h5a
) (
    input wire logic                            clk,
    input wire logic                            rst_n,
    input wire logic [5:0]                      host_addr,
    input wire logic                            host_wr,
    input wire logic                            host_rd,
    input wire logic [7:0]                      host_wdata,
    input wire logic [7:0]                      host_rdata,
    input wire line_iface_pkg::chan_cfg_type [1:0] ch_cfg,
    input wire logic [1:0]                      line_drv_en,
    input wire logic                            sw_reset_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic copy_q;
    wire  rd_ok = host_rd && !host_wr && !sw_reset_active;
    wire  wr_ok = host_wr && !sw_reset_active;

    // Tracks the broadcast bit of the global configuration
    always_ff @(posedge clk) begin
        if (!rst_n || sw_reset_active)
            copy_q <= 1'b0;
        else if (wr_ok && host_addr == 6'h20)
            copy_q <= host_wdata[`GCF_COPY];
    end

    rev_read_a: assert property (
        rd_ok && host_addr == 6'h00 |=> host_rdata == REVISION)
        else $error("revision read mismatch");
    rst_len_a: assert property (
        wr_ok && host_addr == 6'h01 |=> sw_reset_active ##24
        sw_reset_active ##1 !sw_reset_active)
        else $error("software reset length wrong");
    rst_empty_a: assert property (
        rd_ok && host_addr == 6'h01 |=> host_rdata == 8'h00)
        else $error("reset register holds data");
    drv_off_a: assert property (
        sw_reset_active || $fell(sw_reset_active) |-> line_drv_en == 2'b00)
        else $error("line driver enabled after reset");
    cfg_dflt_a: assert property (
        $fell(sw_reset_active) |-> ch_cfg[0].jitter_atten_config == `DEF_JITTER_ATTEN_CONFIG &&
        ch_cfg[1].tcf_pulse == `DEF_TCF_PULSE && ch_cfg[1].term == 8'h00)
        else $error("defaults not restored");
    chan_two_a: assert property (
        wr_ok && host_addr == 6'h22 |=>
        ch_cfg[1].term == ($past(host_wdata) & `MASK_TERM))
        else $error("second channel copy not written");
    local_only_a: assert property (
        wr_ok && !copy_q && host_addr == 6'h02 |=> $stable(ch_cfg[1].term))
        else $error("local write leaked to other channel");
    bcast_copy_a: assert property (
        wr_ok && copy_q && host_addr == 6'h02 |=>
        ch_cfg[1].term == ($past(host_wdata) & `MASK_TERM))
        else $error("broadcast write not copied");
    rsvd_zero_a: assert property (
        rd_ok && host_addr[4:0] inside {[5'h0e:5'h11]} |=> host_rdata == 8'h00)
        else $error("reserved range read nonzero");

    cover property (wr_ok && host_addr == 6'h01);
    cover property (wr_ok && copy_q && host_addr == 6'h02);
    cover property (rd_ok && host_addr == 6'h38);
endmodule

bind line_iface_regs line_iface_regs_checker #(.REVISION(REVISION)) chk (
    .clk(clk), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .ch_cfg(ch_cfg), .line_drv_en(line_drv_en),
    .sw_reset_active(sw_reset_active));

/* dv/host_model.sv */
`timescale 1ns/100ps

module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] host_rdata,
    output logic [5:0]      host_addr,
    output logic            host_wr,
    output logic            host_rd,
    output logic [7:0]      host_wdata
);
    initial begin
        host_addr  = 6'h00;
        host_wr    = 1'b0;
        host_rd    = 1'b0;
        host_wdata = 8'h00;
    end

    // Released lines show inverted values, never the last ones
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        host_addr  <= a;
        host_wdata <= d;
        host_wr    <= 1'b1;
        @(posedge clk);
        host_wr    <= 1'b0;
        host_addr  <= ~a;
        host_wdata <= ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        host_addr <= a;
        host_rd   <= 1'b1;
        @(posedge clk);
        host_rd   <= 1'b0;
        host_addr <= ~a;
        @(negedge clk);
        d = host_rdata;
    endtask
endmodule

/* dv/dual_line_iface_register_map_test.sv */
`timescale 1ns/100ps
`include "line_iface_params.svh"

module dual_line_iface_register_map_test;
    // Arbitrary value
    localparam logic [7:0] REV = 8'hc3;

    logic                            clk = 1'b0;
    logic                            rst_n = 1'b0;
    logic [5:0]                      host_addr;
    logic                            host_wr;
    logic                            host_rd;
    logic [7:0]                      host_wdata;
    logic [7:0]                      host_rdata;
    logic [1:0][7:0]                 line_st = '0;
    logic [1:0][7:0]                 loop_st = '0;
    logic [1:0][7:0]                 irq_ln = '0;
    logic [1:0][7:0]                 irq_er = '0;
    logic [1:0][15:0]                cnt = '0;
    logic [1:0]                      int_ch = 2'h0;
    line_iface_pkg::chan_cfg_type [1:0] ch_cfg;
    logic [1:0]                      drv_en;
    logic [1:0]                      ln_rd;
    logic [1:0]                      er_rd;
    logic [1:0]                      mon;
    logic [1:0]                      pin;
    logic                            gmask;
    logic                            swr;
    integer                          seed = 32'hb27e;
    integer                          n_fail = 0;
    integer                          samples_checked = 0;
    logic [7:0]                      d;
    logic [7:0]                      a1;
    logic [7:0]                      a2;
    logic [4:0]                      o;
    int                              i;

    line_iface_regs #(.REVISION(REV)) dut (
        .clk(clk), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .line_status_in(line_st), .loop_status_in(loop_st),
        .irq_stat_line_in(irq_ln), .irq_stat_err_in(irq_er),
        .err_count_in(cnt), .int_channel_in(int_ch), .ch_cfg(ch_cfg),
        .line_drv_en(drv_en), .line_irq_rd(ln_rd), .err_irq_rd(er_rd),
        .monitor_sel(mon), .irq_global_mask(gmask), .irq_pin_mode(pin),
        .sw_reset_active(swr));

    host_model host (
        .clk(clk), .host_rdata(host_rdata), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata));

    always #20 clk = ~clk;

    // Writable bits of each local register
    function automatic logic [7:0] msk(input logic [4:0] ofs);
        case (ofs)
            5'h02, 5'h03, 5'h05, 5'h06: msk = 8'h3f;
            5'h04, 5'h09, 5'h13, 5'h15: msk = 8'h1f;
            5'h07, 5'h14:               msk = 8'hff;
            5'h08, 5'h0c, 5'h12:        msk = 8'h7f;
            5'h0a:                      msk = 8'h5f;
            5'h0b:                      msk = 8'h33;
            5'h0d:                      msk = 8'h07;
            default:                    msk = 8'h00;
        endcase
    endfunction

    task check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
            n_fail++;
        end
    endtask

    task rc(input logic [5:0] a, input logic [7:0] e);
        host.rd(a, d);
        check(d, e);
    endtask

    task end_of_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task wait_idle;
        @(negedge clk);
        for (int k = 0; k < 100 && swr !== 1'b0; k++)
            @(negedge clk);
        if (swr !== 1'b0) begin
            n_fail++;
            end_of_test;
        end
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rc(6'h03, `DEF_JITTER_ATTEN_CONFIG);
        rc(6'h25, `DEF_TCF_PULSE);
        check({6'h00, drv_en}, 8'h00);
        host.wr(6'h00, 8'($random(seed)));
        rc(6'h00, REV);
        for (i = 2; i < 22; i++) begin
            o = 5'(i);
            a1 = 8'($random(seed));
            a2 = 8'($random(seed));
            host.wr({1'b0, o}, a1);
            host.wr({1'b1, o}, a2);
            rc({1'b0, o}, a1 & msk(o));
            rc({1'b1, o}, a2 & msk(o));
        end
        host.wr(6'h04, 8'h00);
        host.wr(6'h05, 8'h00);
        host.wr(6'h24, 8'h00);
        host.wr(6'h25, 8'h10);
        @(negedge clk);
        check({6'h00, drv_en}, 8'h01);
        @(posedge clk);
        line_st <= {8'($random(seed)), 8'($random(seed))};
        loop_st <= {8'($random(seed)), 8'($random(seed))};
        irq_ln  <= {8'($random(seed)), 8'($random(seed))};
        irq_er  <= {8'($random(seed)), 8'($random(seed))};
        cnt     <= {16'($random(seed)), 16'($random(seed))};
        int_ch  <= 2'($random(seed));
        // Let the new status values settle before expectations read them
        @(negedge clk);
        rc(6'h21, {6'h00, int_ch});
        for (i = 0; i < 2; i++) begin
            rc({i[0], 5'h16}, line_st[i] & 8'h1f);
            rc({i[0], 5'h17}, loop_st[i] & 8'h20);
            rc({i[0], 5'h18}, irq_ln[i] & 8'h1f);
            check({6'h00, ln_rd}, 8'(1 << i));
            rc({i[0], 5'h19}, irq_er[i]);
            check({6'h00, er_rd}, 8'(1 << i));
            rc({i[0], 5'h1a}, cnt[i][7:0]);
            rc({i[0], 5'h1b}, cnt[i][15:8]);
        end
        a1 = 8'($random(seed));
        a2 = 8'($random(seed)) | 8'h08;
        host.wr(6'h20, a2);
        @(negedge clk);
        check({mon, 3'h0, gmask, pin}, a2 & 8'hc7);
        rc(6'h20, a2 & 8'hcf);
        host.wr(6'h02, a1);
        rc(6'h22, a1 & 8'h3f);
        host.wr(6'h2b, a1);
        rc(6'h0b, a1 & 8'h33);
        host.wr(6'h20, 8'h04);
        host.wr(6'h02, 8'h15);
        rc(6'h22, a1 & 8'h3f);
        // Write in the reset shadow must be dropped
        host.wr(6'h01, 8'($random(seed)));
        host.wr(6'h02, 8'h2a);
        wait_idle;
        check({6'h00, drv_en}, 8'h00);
        rc(6'h01, 8'h00);
        rc(6'h02, 8'h00);
        rc(6'h23, `DEF_JITTER_ATTEN_CONFIG);
        rc(6'h20, `DEF_GLOBAL_CFG);
        rc(6'h2c, 8'h00);
        end_of_test;
    end
endmodule
